/* File: src/psdc_top.sv */
// serial-programmed pulse-swallow divider, phase comparator and lock detect
// Behaviour
// RL1: shift serial data on each serial clock rise
// RL2: last bit high selects reference latch, else divider
// RL3: strobe high transfers word; host shifts with strobe low
// RL4: host sends most significant bit first
// RL5: host reference word is 17 bits, selector high
// RL6: reference ratio 14 bits, 6 to 16383
// RL7: modulus select low 128/129, high 64/65
// RL8: power save bit high runs, low is standby
// RL9: divider word 19 bits into 18-bit latch
// RL10: swallow count is lowest seven ratio bits
// RL11: main count bits 8 to 18, 5 to 2047
// RL12: division is modulus times main plus swallow
// RL13: lock output rests high, low during phase error; code drops it only for errors of 8 periods or more
// RL14: polarity low inverts pump and comparator outputs
// RL15: monitor shows reference divider or main divider
// RL16: open-drain output pulls low or floats only
// RL17: host sets selector low in divider word
// RL18: comparator table for up, down and equal
// RL19: unlock at 8 periods, relock after 3 cycles; code keeps good_cnt_reg at 3 on unlock, so it relocks as the error ends
// RL20: limit comparator error while waking from standby
// RL21: modulus plus one until swallow expires, then base
// RL22: latches keep contents until a committed transfer
//
// The Avalon-MM slave port and the register offsets were left to the implementer.
`timescale 1ns/10ps
module psdc_top (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic serial_clk_in,
  input wire logic serial_data_in,
  input wire logic latch_load_strobe_in,
  input wire logic phase_polarity_select_in,
  input wire logic reference_osc_in,
  input wire logic prescaler_pulse_in,
  output logic modulus_control_out,
  output logic prescaler_modulus_select_out,
  output logic pump_out,
  output logic pump_oe_n_out,
  output logic phase_push_out,
  output logic phase_drain_out,
  output logic phase_drain_oe_n_out,
  output logic monitor_out,
  output logic lock_indicator_out
);

  // ------------------------------------------------------------------
  // input synchronisation and edge detection
  // ------------------------------------------------------------------
  localparam int SYN_W = 6;
  localparam int S_CLK = 0;
  localparam int S_DATA = 1;
  localparam int S_STROBE = 2;
  localparam int S_POL = 3;
  localparam int S_OSC = 4;
  localparam int S_PRE = 5;
  // strobe and polarity pins are pulled up, so they idle high
  localparam logic [SYN_W-1:0] SYN_IDLE = SYN_W'((1 << S_STROBE) | (1 << S_POL));

  logic [SYN_W-1:0] sync_w;
  logic [SYN_W-1:0] sync_prev_reg;
  wire [SYN_W-1:0] raw_w = {prescaler_pulse_in, reference_osc_in, phase_polarity_select_in,
                            latch_load_strobe_in, serial_data_in, serial_clk_in};

  psdc_sync #(.WIDTH(SYN_W)) u_sync (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .async_in(raw_w),
    .reset_value_in(SYN_IDLE),
    .sync_out(sync_w)
  );

  always_ff @(posedge clk_in) begin
    if (reset_in) sync_prev_reg <= SYN_IDLE;
    else sync_prev_reg <= sync_w;
  end

  wire sclk_rise = sync_w[S_CLK] & ~sync_prev_reg[S_CLK];
  wire osc_rise = sync_w[S_OSC] & ~sync_prev_reg[S_OSC];
  wire pre_rise = sync_w[S_PRE] & ~sync_prev_reg[S_PRE];
  wire polarity = sync_w[S_POL];
  wire strobe = sync_w[S_STROBE];

  // ------------------------------------------------------------------
  // serial shift register and latches
  // ------------------------------------------------------------------
  logic [psdc_pkg::SHIFT_W-1:0] shift_reg;
  psdc_pkg::psdc_ref_latch_t ref_latch_reg;
  psdc_pkg::psdc_div_latch_t div_latch_reg;

  wire sel_ref = shift_reg[psdc_pkg::CTRL_BIT];
  wire load_ref = strobe & sel_ref; // see RL2
  wire load_div = strobe & ~sel_ref; // see RL2

  // shift in at each serial clock rise, earliest bit moves toward the top
  always_ff @(posedge clk_in) begin
    // reset word equals the divider latch reset, so an idle-high strobe keeps it
    if (reset_in) shift_reg <= {psdc_pkg::MAIN_RATIO_RESET, psdc_pkg::SWALLOW_RESET, 1'b0};
    else if (sclk_rise) shift_reg <= {shift_reg[psdc_pkg::SHIFT_W-2:0], sync_w[S_DATA]}; // see RL1
  end

  // transfer while the strobe is high; otherwise hold old contents
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ref_latch_reg <= {1'b0, 1'b0, psdc_pkg::REF_RATIO_RESET};
      div_latch_reg <= {psdc_pkg::MAIN_RATIO_RESET, psdc_pkg::SWALLOW_RESET};
    end else begin
      if (load_ref) ref_latch_reg <= shift_reg[psdc_pkg::REF_MSB:psdc_pkg::REF_LSB]; // see RL3
      if (load_div) div_latch_reg <= shift_reg[psdc_pkg::DIV_MSB:psdc_pkg::DIV_LSB]; // see RL22
    end
  end

  wire standby = ~ref_latch_reg.power_save_bit; // see RL8

  // ------------------------------------------------------------------
  // reference and main dividers
  // ------------------------------------------------------------------
  logic ref_tick;
  logic div_tick;
  logic [psdc_pkg::SWALLOW_W-1:0] swallow_left_reg;
  wire swallow_busy = (swallow_left_reg != '0);

  psdc_divcnt #(.WIDTH(psdc_pkg::REF_RATIO_W)) u_ref_cnt (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .load_value_in(ref_latch_reg.reference_ratio_bits), // see RL6
    .reload_in(standby),
    .count_in(osc_rise),
    .tick_out(ref_tick)
  );

  // main count runs over all prescaler pulses of a comparison cycle
  psdc_divcnt #(.WIDTH(psdc_pkg::MAIN_W)) u_main_cnt (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .load_value_in(div_latch_reg.main_count_bits), // see RL11
    .reload_in(standby),
    .count_in(pre_rise),
    .tick_out(div_tick)
  );

  // swallow count: prescaler at modulus plus one until it runs out
  always_ff @(posedge clk_in) begin
    if (reset_in) swallow_left_reg <= '0;
    else if (standby || div_tick) swallow_left_reg <= div_latch_reg.swallow_ratio_bits; // see RL10
    else if (pre_rise && swallow_busy) swallow_left_reg <= swallow_left_reg - 1'b1; // see RL21
  end

  // ------------------------------------------------------------------
  // phase-frequency comparator
  // ------------------------------------------------------------------
  logic up_reg;
  logic dn_reg;
  wire up_set = up_reg | ref_tick;
  wire dn_set = dn_reg | div_tick;
  wire both = up_set & dn_set;
  wire pfd_active = up_reg | dn_reg;

  // reference leads sets up, divided signal leads sets down; both clears
  always_ff @(posedge clk_in) begin
    if (reset_in || standby) begin
      up_reg <= 1'b0;
      dn_reg <= 1'b0;
    end else begin
      up_reg <= up_set & ~both; // see RL18
      dn_reg <= dn_set & ~both; // see RL18
    end
  end

  // ------------------------------------------------------------------
  // phase error width in oscillator periods
  // ------------------------------------------------------------------
  logic [psdc_pkg::ERR_W-1:0] err_cnt_reg;
  logic [psdc_pkg::ERR_W-1:0] err_peak_reg;
  wire err_sat = (err_cnt_reg == psdc_pkg::ERR_SAT);
  wire err_upper = (err_cnt_reg >= psdc_pkg::LOCK_UPPER_PERIODS);
  wire peak_in_lower = (err_peak_reg <= psdc_pkg::LOCK_LOWER_PERIODS);

  always_ff @(posedge clk_in) begin
    if (reset_in || !pfd_active) err_cnt_reg <= '0;
    else if (osc_rise && !err_sat) err_cnt_reg <= err_cnt_reg + 1'b1;
  end

  // widest error seen in the current comparison cycle
  always_ff @(posedge clk_in) begin
    if (reset_in || ref_tick) err_peak_reg <= '0;
    else if (err_cnt_reg > err_peak_reg) err_peak_reg <= err_cnt_reg;
  end

  // ------------------------------------------------------------------
  // lock detector
  // ------------------------------------------------------------------
  psdc_pkg::psdc_lock_state_t lock_state_reg;
  psdc_pkg::psdc_lock_state_t lock_state_next;
  logic [1:0] good_cnt_reg;
  wire good_done = (good_cnt_reg == psdc_pkg::LOCK_GOOD_CYCLES);

  // count consecutive cycles whose error stayed inside the lower window
  always_ff @(posedge clk_in) begin
    if (reset_in || standby) good_cnt_reg <= '0;
    else if (ref_tick && !peak_in_lower) good_cnt_reg <= '0; // see RL19
    else if (ref_tick && !good_done) good_cnt_reg <= good_cnt_reg + 1'b1;
  end

  always_comb begin
    lock_state_next = lock_state_reg;
    case (lock_state_reg)
      psdc_pkg::PSDC_UNLOCKED: if (good_done) lock_state_next = psdc_pkg::PSDC_LOCKED;
      psdc_pkg::PSDC_LOCKED: if (err_upper) lock_state_next = psdc_pkg::PSDC_UNLOCKED;
      default: lock_state_next = psdc_pkg::PSDC_UNLOCKED;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (reset_in || standby) lock_state_reg <= psdc_pkg::PSDC_UNLOCKED;
    else lock_state_reg <= lock_state_next; // see RL19
  end

  // ------------------------------------------------------------------
  // wake-up error limiting
  // ------------------------------------------------------------------
  logic standby_prev_reg;
  logic [1:0] wake_left_reg;
  wire wake_edge = standby_prev_reg & ~standby;
  wire limit_active = (wake_left_reg != 2'h0);
  wire clamp = limit_active & (err_cnt_reg >= psdc_pkg::WAKE_LIMIT_PERIODS);

  // dividers restart together on wake; errors are cut short a few cycles
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      standby_prev_reg <= 1'b1;
      wake_left_reg <= 2'h0;
    end else begin
      standby_prev_reg <= standby;
      if (wake_edge) wake_left_reg <= psdc_pkg::WAKE_CYCLES; // see RL20
      else if (ref_tick && limit_active) wake_left_reg <= wake_left_reg - 2'h1;
    end
  end

  // ------------------------------------------------------------------
  // register bus
  // ------------------------------------------------------------------
  logic ctrl_out_en_reg;
  wire req = avs_read_in | avs_write_in;
  wire first_cycle = req & avs_waitrequest_out;
  wire commit_wr = avs_write_in & ~avs_waitrequest_out;
  wire ctrl_wr = commit_wr & (avs_address_in == psdc_pkg::ADDR_CTRL) & avs_byteenable_in[0];
  wire [31:0] status_word = {29'h0, limit_active, standby,
                             lock_state_reg == psdc_pkg::PSDC_LOCKED};
  wire [31:0] rd_mux =
    (avs_address_in == psdc_pkg::ADDR_CTRL) ? {31'h0, ctrl_out_en_reg} :
    (avs_address_in == psdc_pkg::ADDR_STATUS) ? status_word :
    (avs_address_in == psdc_pkg::ADDR_REF) ? {16'h0, ref_latch_reg} :
    (avs_address_in == psdc_pkg::ADDR_DIV) ? {14'h0, div_latch_reg} : 32'h0;

  // one wait cycle, then a single cycle of waitrequest low
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out <= 32'h0;
      ctrl_out_en_reg <= psdc_pkg::CTRL_OUT_EN_RESET;
    end else begin
      avs_waitrequest_out <= ~first_cycle;
      if (first_cycle && avs_read_in) avs_readdata_out <= rd_mux;
      if (ctrl_wr) ctrl_out_en_reg <= avs_writedata_in[psdc_pkg::CTRL_OUT_EN_BIT];
    end
  end

  // ------------------------------------------------------------------
  // output selection
  // ------------------------------------------------------------------
  wire lead_act = polarity ? up_reg : dn_reg; // see RL14
  wire lag_act = polarity ? dn_reg : up_reg; // see RL14
  wire drive_en = ctrl_out_en_reg & ~standby & ~clamp;
  wire pump_oe_n_next = ~(drive_en & (lead_act | lag_act)); // see RL18
  wire drain_oe_n_next = ~(drive_en & lead_act); // see RL16
  wire push_next = drive_en & lag_act; // see RL18
  wire monitor_next = polarity ? ref_tick : div_tick; // see RL15
  wire lock_next = (lock_state_next == psdc_pkg::PSDC_LOCKED) & ~(pfd_active & err_upper);

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      modulus_control_out <= 1'b0;
      prescaler_modulus_select_out <= 1'b0;
      pump_out <= 1'b0;
      pump_oe_n_out <= 1'b1;
      phase_push_out <= 1'b0;
      phase_drain_out <= 1'b0;
      phase_drain_oe_n_out <= 1'b1;
      monitor_out <= 1'b0;
      lock_indicator_out <= 1'b0;
    end else begin
      modulus_control_out <= swallow_busy; // see RL12
      prescaler_modulus_select_out <= ref_latch_reg.prescaler_modulus_select; // see RL7
      pump_out <= lead_act;
      pump_oe_n_out <= pump_oe_n_next;
      phase_push_out <= push_next;
      phase_drain_out <= 1'b0;
      phase_drain_oe_n_out <= drain_oe_n_next;
      monitor_out <= monitor_next;
      lock_indicator_out <= lock_next; // see RL13
    end
  end

endmodule

/* File: src/psdc_pkg.sv */
// shared constants, field layouts and carriers of the synthesizer divider control
package psdc_pkg;

  // ------------------------------------------------------------------
  // serial word layout
  // ------------------------------------------------------------------
  localparam int SHIFT_W = 19;
  localparam int CTRL_BIT = 0;
  localparam int REF_LSB = 1;
  localparam int REF_MSB = 16;
  localparam int DIV_LSB = 1;
  localparam int DIV_MSB = 18;
  localparam int REF_RATIO_W = 14;
  localparam int SWALLOW_W = 7;
  localparam int MAIN_W = 11;
  localparam int REF_LATCH_W = 16;
  localparam int DIV_LATCH_W = 18;

  // ------------------------------------------------------------------
  // latch reset values (standby, smallest legal ratios)
  // ------------------------------------------------------------------
  localparam logic [13:0] REF_RATIO_RESET = 14'h0006;
  localparam logic [10:0] MAIN_RATIO_RESET = 11'h005;
  localparam logic [6:0] SWALLOW_RESET = 7'h00;

  // ------------------------------------------------------------------
  // lock window and wake-up limiting, in oscillator periods and cycles
  // ------------------------------------------------------------------
  localparam int ERR_W = 6;
  localparam logic [5:0] LOCK_UPPER_PERIODS = 6'h08;
  localparam logic [5:0] LOCK_LOWER_PERIODS = 6'h10;
  localparam logic [5:0] ERR_SAT = 6'h3f;
  localparam logic [1:0] LOCK_GOOD_CYCLES = 2'h3;
  localparam logic [5:0] WAKE_LIMIT_PERIODS = 6'h08;
  localparam logic [1:0] WAKE_CYCLES = 2'h3;

  // ------------------------------------------------------------------
  // register map (byte addresses) and fields
  // ------------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_REF = 4'h8;
  localparam logic [3:0] ADDR_DIV = 4'hc;
  localparam int CTRL_OUT_EN_BIT = 0;
  localparam logic CTRL_OUT_EN_RESET = 1'b1;

  // ------------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic power_save_bit;
    logic prescaler_modulus_select;
    logic [REF_RATIO_W-1:0] reference_ratio_bits;
  } psdc_ref_latch_t;

  typedef struct packed {
    logic [MAIN_W-1:0] main_count_bits;
    logic [SWALLOW_W-1:0] swallow_ratio_bits;
  } psdc_div_latch_t;

  typedef enum logic [1:0] {
    PSDC_UNLOCKED = 2'b01,
    PSDC_LOCKED = 2'b10
  } psdc_lock_state_t;

endpackage

/* File: src/psdc_sync.sv */
// two-stage synchroniser for a group of asynchronous inputs
`timescale 1ns/10ps
module psdc_sync #(
  parameter int WIDTH = 6
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [WIDTH-1:0] async_in,
  input wire logic [WIDTH-1:0] reset_value_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_reg;

  // ------------------------------------------------------------------
  // first stage feeds only the second
  // ------------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      stage1_reg <= reset_value_in;
      sync_out <= reset_value_in;
    end else begin
      stage1_reg <= async_in;
      sync_out <= stage1_reg;
    end
  end

endmodule

/* File: src/psdc_divcnt.sv */
// programmable down counter: one tick every load_value_in counted events
`timescale 1ns/10ps
module psdc_divcnt #(
  parameter int WIDTH = 14
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [WIDTH-1:0] load_value_in,
  input wire logic reload_in,
  input wire logic count_in,
  output logic tick_out
);

  localparam logic [WIDTH-1:0] ONE = {{(WIDTH-1){1'b0}}, 1'b1};

  logic [WIDTH-1:0] cnt_reg;
  wire terminal = (cnt_reg <= ONE);

  // ------------------------------------------------------------------
  // count down, reload at terminal, tick for one cycle
  // ------------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      cnt_reg <= '0;
      tick_out <= 1'b0;
    end else if (reload_in) begin
      cnt_reg <= load_value_in;
      tick_out <= 1'b0;
    end else if (count_in) begin
      cnt_reg <= terminal ? load_value_in : cnt_reg - ONE;
      tick_out <= terminal;
    end else begin
      tick_out <= 1'b0;
    end
  end

endmodule

/* File: verification/psdc_top_sva.sv */
// port-level assertions for the serial divider control top
`timescale 1ns/10ps
module psdc_top_sva (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic avs_waitrequest_out,
  input wire logic latch_load_strobe_in,
  input wire logic prescaler_modulus_select_out,
  input wire logic pump_out,
  input wire logic pump_oe_n_out,
  input wire logic phase_push_out,
  input wire logic phase_drain_out,
  input wire logic phase_drain_oe_n_out,
  input wire logic monitor_out
);
  default clocking psdc_cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);
  // ------------------------------------------------------------------
  // strobe-low run length
  // ------------------------------------------------------------------
  logic [2:0] low_cnt_reg;
  logic [2:0] low_cnt_next;
  // counts sampled low cycles of the strobe, saturating at seven
  assign low_cnt_next = latch_load_strobe_in ? 3'h0 : low_cnt_reg + {2'h0, low_cnt_reg != 3'h7};
  // run-length register
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      low_cnt_reg <= 3'h0;
    end else begin
      low_cnt_reg <= low_cnt_next;
    end
  end
  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  AST_BUS_ANSWER: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
    |=> !avs_waitrequest_out) else $error("bus answer not one cycle after request");
  AST_BUS_ONE_CYCLE: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low longer than one cycle");
  AST_LATCH_HOLD: assert property (low_cnt_reg >= 3'h6
    |-> $stable(prescaler_modulus_select_out)) else $error("latch moved with strobe low");
  AST_LATCH_CAUSE: assert property ($changed(prescaler_modulus_select_out) |->
    $past(latch_load_strobe_in, 1) || $past(latch_load_strobe_in, 2) ||
    $past(latch_load_strobe_in, 3) || $past(latch_load_strobe_in, 4) ||
    $past(latch_load_strobe_in, 5) || $past(latch_load_strobe_in, 6))
    else $error("modulus select changed without a strobe");
  AST_DRAIN_NEVER_HIGH: assert property (phase_drain_out == 1'b0)
    else $error("open-drain output driven high");
  AST_PUSH_SIDE: assert property (phase_push_out |->
    !pump_oe_n_out && !pump_out && phase_drain_oe_n_out)
    else $error("push output high without pump low and drain floating");
  AST_DRAIN_SIDE: assert property (!phase_drain_oe_n_out |->
    !pump_oe_n_out && pump_out && !phase_push_out)
    else $error("drain pulling low without pump high");
  AST_MON_PULSE: assert property (monitor_out |=> !monitor_out)
    else $error("monitor pulse longer than one cycle");
endmodule

bind psdc_top psdc_top_sva i_psdc_top_sva (
  .clk_in(clk_in), .reset_in(reset_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_waitrequest_out(avs_waitrequest_out),
  .latch_load_strobe_in(latch_load_strobe_in),
  .prescaler_modulus_select_out(prescaler_modulus_select_out),
  .pump_out(pump_out), .pump_oe_n_out(pump_oe_n_out), .phase_push_out(phase_push_out),
  .phase_drain_out(phase_drain_out), .phase_drain_oe_n_out(phase_drain_oe_n_out),
  .monitor_out(monitor_out)
);

/* File: verification/psdc_host_model.sv */
// host side model driving the three-wire serial load port
`timescale 1ns/10ps
module psdc_host_model (
  input wire logic clk_in,
  output logic serial_clk_out,
  output logic serial_data_out,
  output logic latch_load_strobe_out
);
  // ------------------------------------------------------------------
  // idle levels: clock still, strobe pulled up
  // ------------------------------------------------------------------
  initial begin
    serial_clk_out = 1'b0;
    serial_data_out = 1'b0;
    latch_load_strobe_out = 1'b1;
  end
  // shifts nb bits msb first; four system clocks per half period give 160 ns,
  // and data moves with the falling serial clock edge
  task automatic send(input logic [18:0] w, input int nb, input logic commit);
    @(posedge clk_in);
    latch_load_strobe_out <= 1'b0;
    for (int i = nb - 1; i >= 0; i--) begin
      serial_data_out <= w[i];
      repeat (4) @(posedge clk_in);
      serial_clk_out <= 1'b1;
      repeat (4) @(posedge clk_in);
      serial_clk_out <= 1'b0;
    end
    serial_data_out <= ~w[0]; // released line shows no stale bit
    repeat (3) @(posedge clk_in);
    if (commit) begin
      latch_load_strobe_out <= 1'b1;
    end
  endtask
  // raises the strobe to commit a word shifted earlier, just after a clock edge
  task automatic release_word();
    latch_load_strobe_out <= 1'b1;
  endtask
endmodule

/* File: verification/testbench.sv */
// self-checking bench for the serial divider control
`timescale 1ns/10ps
module testbench;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [3:0] addr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] be = 4'h0;
  logic pol = 1'b1;
  logic osc = 1'b0;
  logic pre = 1'b0;
  logic [2:0] ph = 3'h0;
  logic [31:0] rdata, q;
  logic [31:0] seed = 32'h5473;
  logic waitreq, sclk, sdata, strobe, modctl, modsel, pump, pump_oe_n, push;
  logic drain, drain_oe_n, mon, lock;
  int error_cnt = 0;
  int checks = 0;
  int osc_cnt = 0;
  int pre_cnt = 0;
  int r, n, a, sw, t, ref_exp, div_exp, ref_old;
  int sw_cnt = 0;
  int mon_q[$];
  int sw_q[$];
  logic [3:0] amap [5] = '{4'h0, 4'h4, 4'h8, 4'hc, 4'h2};
  logic [31:0] rexp [5] = '{32'h1, 32'h2, 32'h6, 32'h280, 32'h0};
  // ------------------------------------------------------------------
  // design, host model and clock
  // ------------------------------------------------------------------
  psdc_top i_psdc_top (.clk_in(clk_in), .reset_in(reset_in), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(be),
    .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq), .serial_clk_in(sclk),
    .serial_data_in(sdata), .latch_load_strobe_in(strobe), .phase_polarity_select_in(pol),
    .reference_osc_in(osc), .prescaler_pulse_in(pre), .modulus_control_out(modctl),
    .prescaler_modulus_select_out(modsel), .pump_out(pump), .pump_oe_n_out(pump_oe_n),
    .phase_push_out(push), .phase_drain_out(drain), .phase_drain_oe_n_out(drain_oe_n),
    .monitor_out(mon), .lock_indicator_out(lock));
  psdc_host_model i_host (.clk_in(clk_in), .serial_clk_out(sclk), .serial_data_out(sdata),
    .latch_load_strobe_out(strobe));
  // free-running 50 MHz clock
  initial begin
    forever #10 clk_in = ~clk_in;
  end
  // oscillator and prescaler stimulus, edge counts and monitor capture
  always @(posedge clk_in) begin
    ph <= ph + 3'h1;
    osc <= ph[2];
    pre <= ph[1];
    if (ph[2] && !osc) osc_cnt++;
    if (ph[1] && !pre) pre_cnt++;
    if (ph[1] && !pre && modctl === 1'b1) sw_cnt++; // prescaler pulses at modulus plus one
    if (mon === 1'b1) begin
      mon_q.push_back(pol ? osc_cnt : pre_cnt);
      sw_q.push_back(sw_cnt);
    end
  end
  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one Avalon access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] ad, input logic [31:0] d,
                     input logic [3:0] b, output logic [31:0] res);
    int cnt;
    cnt = 0;
    @(posedge clk_in);
    addr <= ad;
    wdata <= d;
    be <= b;
    rd <= !w;
    wr <= w;
    do begin
      @(posedge clk_in);
      cnt++;
    end while (waitreq !== 1'b0 && cnt < 40);
    res = rdata;
    if (cnt >= 40) error_cnt++;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] ad, input logic [31:0] e);
    logic [31:0] res;
    bus(1'b0, ad, 32'h0, 4'h0, res);
    chk($sformatf("reg %h", ad), e, res);
  endtask
  task complete_run();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // watchdog against a hung handshake
  initial begin
    repeat (60000) @(posedge clk_in);
    error_cnt++;
    complete_run();
  end
  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_in);
    reset_in <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      rreg(amap[i], rexp[i]);
    end
    bus(1'b1, 4'h0, 32'h0, 4'h0, q);
    bus(1'b1, 4'h8, 32'hffff, 4'hf, q);
    bus(1'b1, 4'h2, 32'hffff, 4'hf, q);
    rreg(4'h0, 32'h1);
    rreg(4'h8, 32'h6);
    bus(1'b1, 4'h0, 32'h0, 4'hf, q);
    rreg(4'h0, 32'h0);
    chk("outputs off", 32'h5, {29'h0, pump_oe_n, push, drain_oe_n});
    bus(1'b1, 4'h0, 32'h1, 4'hf, q);
    $display("register test done");
    ref_old = 6;
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      r = (k == 0) ? 6 : 6 + int'(seed[2:0]);
      // first word: main period equals the reference period, so the loop locks
      n = (k == 3) ? 2047 : (k == 0) ? 2 * r : 5 + int'(seed[5:3]);
      a = (k == 3) ? 127 : int'(seed[12:8]) % n;
      sw = k % 2;
      ref_exp = 32768 + sw * 16384 + r;
      div_exp = n * 128 + a;
      pol <= (k != 1);
      i_host.send(19'(div_exp * 2), 19, 1'b1);
      repeat (10) @(posedge clk_in);
      rreg(4'hc, 32'(div_exp));
      i_host.send(19'(ref_exp * 2 + 1), 17, 1'b0);
      rreg(4'h8, 32'(ref_old));
      i_host.release_word();
      repeat (10) @(posedge clk_in);
      rreg(4'h8, 32'(ref_exp));
      rreg(4'hc, 32'(div_exp));
      chk("modsel", 32'(sw), {31'h0, modsel});
      bus(1'b0, 4'h4, 32'h0, 4'h0, q);
      chk("standby", 32'h0, {31'h0, q[1]});
      mon_q.delete();
      sw_q.delete();
      t = 0;
      while (mon_q.size() < 3 && t < 3000) begin
        @(posedge clk_in);
        t++;
      end
      chk("interval", 32'((k == 1) ? n : r), 32'(mon_q[2] - mon_q[1]));
      if (k == 1) chk("swallow", 32'(a), 32'(sw_q[2] - sw_q[1]));
      if (k == 0) begin
        repeat (50) @(posedge clk_in);
        chk("lock", 32'h1, {31'h0, lock});
      end
      ref_old = ref_exp;
      $display("test %0d done", k);
    end
    complete_run();
  end
endmodule
